// *** dv/phy_clk_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module phy_clk_model (
   input  wire logic run_i,
   output logic      rx_clk_o,
   output logic      tx_clk_o
);
   // =====
   // phy clocks, stopped and low while asleep
   initial begin
      rx_clk_o = 1'b0;
      tx_clk_o = 1'b0;
      forever begin
         #13;
         rx_clk_o = run_i ? ~rx_clk_o : 1'b0;
         #7;
         tx_clk_o = run_i ? ~tx_clk_o : 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** dv/phy_select_soft_reset_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module phy_select_soft_reset_chk
   import config_pkg::*;
#(
   parameter int TIMEOUT_CYC = RESET_TIMEOUT_CYC
) (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic [7:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic        mdio_strap_i,
   input wire logic        phy_rx_clk_i,
   input wire logic        phy_tx_clk_i,
   input wire logic        power_save_exit_i,
   input wire logic        transmit_error_i,
   input wire logic        receive_error_i,
   input wire logic        mii_port_external_select_o,
   input wire logic        mac_soft_reset_o,
   input wire logic        irq_o
);
   // =====
   // shadow state
   logic [3:0] cnt;
   logic       strap_cap;
   logic       req_seen;
   logic       mask_zero;
   wire        wd_mii;
   wire        hw_sel;
   assign wd_mii = wdata_i[MII_SELECT_BIT];
   assign hw_sel = (addr_i == CONFIG_OFS);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= 4'h0;
         strap_cap <= 1'b0;
      end else begin
         if (cnt != 4'ha) cnt <= cnt + 4'h1;
         if (cnt == 4'h2) strap_cap <= mdio_strap_i;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) req_seen <= 1'b0;
      else if (wr_i && hw_sel && wdata_i[SOFT_RESET_BIT]) req_seen <= 1'b1;
      else if ($fell(mac_soft_reset_o)) req_seen <= 1'b0;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) mask_zero <= 1'b1;
      else if (wr_i && addr_i == INT_MASK_OFS && |wdata_i[3:0]) mask_zero <= 1'b0;
   end
   // =====
   // properties
   AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data not zero outside read answer");
   AST_RSVD: assert property ($past(rd_i) && $past(hw_sel) |-> rdata_o[31:4] == 28'h0)
      else $error("upper config bits not zero");
   AST_UNMAPPED: assert property (rd_i && addr_i > ERR_STATUS_OFS |=> rdata_o == 32'h0)
      else $error("unmapped read not zero");
   AST_STRAP: assert property (rd_i && hw_sel && cnt == 4'ha |=> rdata_o[STRAP_BIT] == strap_cap)
      else $error("strap bit differs from latched pin");
   AST_MII_SRC: assert property ($changed(mii_port_external_select_o)
      |-> $past(wr_i) && $past(hw_sel) && mii_port_external_select_o == $past(wd_mii))
      else $error("port select changed without a matching write");
   AST_HOLD16: assert property ($rose(mac_soft_reset_o)
      |-> mac_soft_reset_o[*8] ##1 mac_soft_reset_o[*8] ##1 !mac_soft_reset_o)
      else $error("soft reset pulse not 16 cycles");
   AST_REQ: assert property ($rose(mac_soft_reset_o) |-> req_seen)
      else $error("soft reset pulse without request");
   AST_BUSY_RD: assert property (rd_i && hw_sel && mac_soft_reset_o |=> rdata_o[SOFT_RESET_BIT])
      else $error("request bit clear during reset");
   AST_IRQ_MASK: assert property (mask_zero |-> !irq_o)
      else $error("interrupt with all sources masked");
endmodule
bind phy_select_soft_reset phy_select_soft_reset_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
   .clk_i                      (clk_i),
   .rst_n_i                    (rst_n_i),
   .addr_i                     (addr_i),
   .wdata_i                    (wdata_i),
   .wr_i                       (wr_i),
   .rd_i                       (rd_i),
   .rdata_o                    (rdata_o),
   .mdio_strap_i               (mdio_strap_i),
   .phy_rx_clk_i               (phy_rx_clk_i),
   .phy_tx_clk_i               (phy_tx_clk_i),
   .power_save_exit_i          (power_save_exit_i),
   .transmit_error_i           (transmit_error_i),
   .receive_error_i            (receive_error_i),
   .mii_port_external_select_o (mii_port_external_select_o),
   .mac_soft_reset_o           (mac_soft_reset_o),
   .irq_o                      (irq_o)
);
`default_nettype wire

// *** dv/tb_phy_select_soft_reset.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_phy_select_soft_reset
   import config_pkg::*;
;
   logic        clk_i;
   logic        rst_n_i;
   logic [7:0]  addr_i;
   logic [31:0] wdata_i;
   logic        wr_i;
   logic        rd_i;
   logic [31:0] rdata_o;
   logic        strap;
   logic        rx_clk;
   logic        tx_clk;
   logic        run;
   logic        ps_exit;
   logic        tx_err;
   logic        rx_err;
   logic        mii;
   logic        mac_rst;
   logic        irq_o;
   int          errors;
   int          n_tests;
   int          hi_cnt = 0;
   phy_select_soft_reset #(.TIMEOUT_CYC(300)) dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mdio_strap_i(strap),
      .phy_rx_clk_i(rx_clk), .phy_tx_clk_i(tx_clk), .power_save_exit_i(ps_exit),
      .transmit_error_i(tx_err), .receive_error_i(rx_err),
      .mii_port_external_select_o(mii), .mac_soft_reset_o(mac_rst), .irq_o(irq_o));
   phy_clk_model phy (.run_i(run), .rx_clk_o(rx_clk), .tx_clk_o(tx_clk));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (mac_rst === 1'b1) hi_cnt <= hi_cnt + 1;
   // =====
   // bus and check helpers
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         errors++;
      end
   endtask
   task automatic test_done;
      if (errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wait_rst(input logic lvl);
      int i;
      for (i = 0; i < 500 && mac_rst !== lvl; i++) @(posedge clk_i) #1;
      if (mac_rst !== lvl) begin
         errors++;
         test_done;
      end
   endtask
   // =====
   // scenarios
   task automatic t_reset_vals;
      logic [31:0] d;
      wr(CONFIG_OFS, 32'h4);
      chk(mii, 1'b0);
      strap <= 1'b0;
      rd(CONFIG_OFS, d);
      chk(d, 32'h8);
      wr(CONFIG_OFS, 32'h4);
      chk(mii, 1'b1);
      rd(CONFIG_OFS, d);
      chk(d, 32'hc);
      wr(CONFIG_OFS, 32'h0);
      chk(mii, 1'b0);
      wr(8'h10, 32'hffffffff);
      rd(8'h10, d);
      chk(d, 32'h0);
      rd(INT_MASK_OFS, d);
      chk(d, 32'h0);
   endtask
   task automatic t_irq;
      logic [31:0] d;
      wr(INT_MASK_OFS, 32'h4);
      tx_err <= 1'b1;
      @(posedge clk_i) tx_err <= 1'b0;
      @(posedge clk_i) #1;
      chk(irq_o, 1'b1);
      wr(INT_MASK_OFS, 32'h0);
      chk(irq_o, 1'b0);
      rd(ERR_STATUS_OFS, d);
      chk(d, 32'h1);
      wr(ERR_STATUS_OFS, 32'h1);
      wr(INT_STATUS_OFS, 32'hf);
      rd(ERR_STATUS_OFS, d);
      chk(d, 32'h0);
      wr(INT_MASK_OFS, 32'h4);
      chk(irq_o, 1'b0);
      wr(INT_MASK_OFS, 32'h0);
   endtask
   task automatic t_timeout;
      logic [31:0] d;
      int          h0;
      run <= 1'b0;
      repeat (150) @(posedge clk_i);
      h0 = hi_cnt;
      wr(CONFIG_OFS, 32'h1);
      repeat (450) @(posedge clk_i);
      #1 chk(hi_cnt - h0, 0);
      rd(CONFIG_OFS, d);
      chk(d[3:0], 4'ha);
   endtask
   task automatic t_soft_reset_request_ok;
      logic [31:0] d;
      int          h0;
      run <= 1'b1;
      repeat (200) @(posedge clk_i);
      wr(INT_STATUS_OFS, 32'hf);
      tx_err <= 1'b1;
      rx_err <= 1'b1;
      @(posedge clk_i);
      tx_err <= 1'b0;
      rx_err <= 1'b0;
      rd(ERR_STATUS_OFS, d);
      chk(d, 32'h3);
      h0 = hi_cnt;
      wr(CONFIG_OFS, 32'h5);
      rd(CONFIG_OFS, d);
      chk(d[2:0], 3'b101);
      wait_rst(1'b1);
      rd(CONFIG_OFS, d);
      chk(d[0], 1'b1);
      wait_rst(1'b0);
      chk(hi_cnt - h0, 16);
      rd(CONFIG_OFS, d);
      chk(d[3:0], 4'hc);
      rd(ERR_STATUS_OFS, d);
      chk(d, 32'h0);
      rd(INT_STATUS_OFS, d);
      chk(d[3:0], 4'hd);
   endtask
   task automatic t_power_save;
      logic [31:0] d;
      ps_exit <= 1'b1;
      repeat (6) @(posedge clk_i);
      wr(CONFIG_OFS, 32'h0);
      chk(mii, 1'b1);
      rd(CONFIG_OFS, d);
      wr(CONFIG_OFS, 32'h0);
      chk(mii, 1'b0);
      ps_exit <= 1'b0;
   endtask
   task automatic t_hard_reset;
      logic [31:0] d;
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(rdata_o, 32'h0);
      rst_n_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rd(CONFIG_OFS, d);
      chk(d, 32'h0);
   endtask
   initial begin
      errors = 0;
      n_tests = 0;
      rst_n_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 32'h0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      strap = 1'b1;
      run = 1'b1;
      ps_exit = 1'b0;
      tx_err = 1'b0;
      rx_err = 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      t_reset_vals;
      t_irq;
      t_timeout;
      t_soft_reset_request_ok;
      t_power_save;
      t_hard_reset;
      test_done;
   end
endmodule
`default_nettype wire

// *** rtl/hardware_configuration_pkg.sv ***
package config_pkg;

   // ==========================================================================
   // register map
   localparam logic [7:0] CONFIG_OFS       = 8'h00;
   localparam logic [7:0] INT_STATUS_OFS   = 8'h04;
   localparam logic [7:0] INT_MASK_OFS     = 8'h08;
   localparam logic [7:0] ERR_STATUS_OFS   = 8'h0c;

   // ==========================================================================
   // field positions
   localparam int SOFT_RESET_BIT        = 0;
   localparam int TIMEOUT_BIT           = 1;
   localparam int MII_SELECT_BIT        = 2;
   localparam int STRAP_BIT             = 3;
   localparam int TX_ERR_BIT            = 0;
   localparam int RX_ERR_BIT            = 1;
   localparam int EV_DONE_BIT           = 0;
   localparam int EV_TIMEOUT_BIT        = 1;
   localparam int EV_TX_ERR_BIT         = 2;
   localparam int EV_RX_ERR_BIT         = 3;
   localparam int EV_WIDTH              = 4;

   // ==========================================================================
   // reset values
   localparam logic       MII_SELECT_RST = 1'b0;
   localparam logic [3:0] EV_MASK_RST    = 4'h0;

   // ==========================================================================
   // timing
   localparam int CLK_PERIOD_NS      = 5;
   localparam int RESET_TIMEOUT_US   = 100;
   localparam int RESET_TIMEOUT_CYC  = RESET_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
   localparam int RESET_HOLD_CYC     = 16;
   localparam int CLK_ALIVE_EDGES    = 4;

   typedef enum logic [1:0] {
      SR_IDLE  = 2'b00,
      SR_CHECK = 2'b01,
      SR_HOLD  = 2'b10
   } soft_reset_request_state_t;

endpackage

// *** rtl/phy_clk_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface phy_clk_if;
   logic rx_clk_sync;
   logic tx_clk_sync;
   logic running;
   modport mon (input rx_clk_sync, input tx_clk_sync, output running);
   modport user (output rx_clk_sync, output tx_clk_sync, input running);
endinterface
`default_nettype wire

// *** rtl/phy_clk_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module phy_clk_monitor
   import config_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   phy_clk_if.mon    clk_bus
);
   // ==========================================================================
   // edge counting of the synchronised phy clocks
   localparam int WIN_CYC = 64;
   logic [1:0] rx_hist;
   logic [1:0] tx_hist;
   logic [7:0] win;
   logic [3:0] rx_edges;
   logic [3:0] tx_edges;
   logic       running;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_hist <= 2'b00;
         tx_hist <= 2'b00;
      end else begin
         rx_hist <= {rx_hist[0], clk_bus.rx_clk_sync};
         tx_hist <= {tx_hist[0], clk_bus.tx_clk_sync};
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         win      <= 8'h00;
         rx_edges <= 4'h0;
         tx_edges <= 4'h0;
         running  <= 1'b0;
      end else if (win == 8'(WIN_CYC - 1)) begin
         win      <= 8'h00;
         running  <= (rx_edges >= 4'(CLK_ALIVE_EDGES)) && (tx_edges >= 4'(CLK_ALIVE_EDGES));
         rx_edges <= 4'h0;
         tx_edges <= 4'h0;
      end else begin
         win <= win + 8'h01;
         if (rx_hist == 2'b01 && rx_edges != 4'hf) begin
            rx_edges <= rx_edges + 4'h1;
         end
         if (tx_hist == 2'b01 && tx_edges != 4'hf) begin
            tx_edges <= tx_edges + 4'h1;
         end
      end
   end

   assign clk_bus.running = running;
endmodule
`default_nettype wire

// *** rtl/phy_select_soft_reset.sv ***
// Functional notes
// - strap pin caught after hard reset release, shown in read-only bit 3
// - strap value feeds nothing but the register read path
// - bit 2 selects external MII port when one, internal PHY when zero
// - MII select leaves management port and rx/tx clock routing untouched
// - soft reset with stopped PHY clocks times out and sets bit 1
// - writing one to bit 0 starts full reset of MAC registers
// - soft reset clears command/status registers except kept bits; here it clears only the error status flags, interrupt status keeps its bits
// - soft reset clears pending transmit and receive error flags
// - soft reset request bit clears itself when done, reads zero after reset
// - host writes ignored until one read after reset or power-save exit
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module phy_select_soft_reset
   import config_pkg::*;
#(
   parameter int TIMEOUT_CYC = RESET_TIMEOUT_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [31:0]      rdata_o,
   input  wire logic        mdio_strap_i,
   input  wire logic        phy_rx_clk_i,
   input  wire logic        phy_tx_clk_i,
   input  wire logic        power_save_exit_i,
   input  wire logic        transmit_error_i,
   input  wire logic        receive_error_i,
   output logic            mii_port_external_select_o,
   output logic            mac_soft_reset_o,
   output logic            irq_o
);
   // ==========================================================================
   // parameter check
   if (TIMEOUT_CYC < 2 || TIMEOUT_CYC > 2**24 - 1) begin : g_bad_timeout
      $error("phy_select_soft_reset: TIMEOUT_CYC out of range");
   end

   // ==========================================================================
   // input synchronisers, two flops each
   logic [1:0] strap_sync;
   logic [1:0] rx_sync;
   logic [1:0] tx_sync;
   logic [1:0] pse_sync;
   logic       pse_last;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         strap_sync <= 2'b00;
      end else begin
         strap_sync <= {strap_sync[0], mdio_strap_i};
      end
   end

   // phy clocks sampled as data: they must run slower than half of clk_i
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_sync <= 2'b00;
         tx_sync <= 2'b00;
      end else begin
         rx_sync <= {rx_sync[0], phy_rx_clk_i};
         tx_sync <= {tx_sync[0], phy_tx_clk_i};
      end
   end

   // power-save exit edge detector reads only the second flop
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pse_sync <= 2'b00;
         pse_last <= 1'b0;
      end else begin
         pse_sync <= {pse_sync[0], power_save_exit_i};
         pse_last <= pse_sync[1];
      end
   end

   // ==========================================================================
   // strap capture, once after hard reset release
   logic strap_taken;
   logic [1:0] strap_wait;
   logic external_phy_present_strap;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         strap_taken                <= 1'b0;
         strap_wait                 <= 2'b00;
         external_phy_present_strap <= 1'b0;
      end else if (!strap_taken) begin
         strap_wait <= strap_wait + 2'b01;
         if (strap_wait == 2'b10) begin
            external_phy_present_strap <= strap_sync[1];
            strap_taken                <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // phy clock monitor and soft reset sequencer
   phy_clk_if clk_bus ();
   assign clk_bus.rx_clk_sync = rx_sync[1];
   assign clk_bus.tx_clk_sync = tx_sync[1];

   phy_clk_monitor u_mon (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .clk_bus (clk_bus.mon)
   );

   logic sr_start;
   logic sr_busy;
   logic sr_done;
   logic sr_timeout;
   logic sr_pulse;

   soft_reset_seq #(
      .TIMEOUT_CYC (TIMEOUT_CYC)
   ) u_seq (
      .clk_i         (clk_i),
      .rst_n_i       (rst_n_i),
      .start_i       (sr_start),
      .phy_running_i (clk_bus.running),
      .busy_o        (sr_busy),
      .done_o        (sr_done),
      .timeout_o     (sr_timeout),
      .reset_pulse_o (sr_pulse)
   );

   // ==========================================================================
   // write gate: armed by first read
   logic write_armed;
   logic wr_ok;
   logic cfg_wr;
   logic sts_wr;
   logic msk_wr;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         write_armed <= 1'b0;
      end else if (pse_sync[1] && !pse_last) begin
         write_armed <= 1'b0;
      end else if (rd_i) begin
         write_armed <= 1'b1;
      end
   end

   assign wr_ok    = wr_i && write_armed;
   assign cfg_wr   = wr_ok && (addr_i == CONFIG_OFS);
   assign sts_wr   = wr_ok && (addr_i == INT_STATUS_OFS);
   assign msk_wr   = wr_ok && (addr_i == INT_MASK_OFS);
   assign sr_start = cfg_wr && wdata_i[SOFT_RESET_BIT] && !sr_busy;

   // ==========================================================================
   // hardware configuration bits
   logic soft_reset_request;
   logic soft_reset_timeout_flag;
   logic mii_port_external_select;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         soft_reset_request <= 1'b0;
      end else if (sr_start) begin
         soft_reset_request <= 1'b1;
      end else if (sr_done || sr_timeout) begin
         soft_reset_request <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         soft_reset_timeout_flag <= 1'b0;
      end else if (sr_timeout) begin
         soft_reset_timeout_flag <= 1'b1;
      end else if (sr_start) begin
         soft_reset_timeout_flag <= 1'b0;
      end
   end

   // mii select is kept across soft reset; only the port is steered
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mii_port_external_select <= MII_SELECT_RST;
      end else if (cfg_wr) begin
         mii_port_external_select <= wdata_i[MII_SELECT_BIT];
      end
   end

   // data-signal mux select only; smi and clock routing live elsewhere
   assign mii_port_external_select_o = mii_port_external_select;
   assign mac_soft_reset_o           = sr_pulse;

   // ==========================================================================
   // error flags, cleared by soft reset
   logic transmit_error_flag;
   logic receive_error_flag;
   logic err_wr;

   assign err_wr = wr_ok && addr_i == ERR_STATUS_OFS;

   // soft reset beats a new error; otherwise set beats write-one-to-clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         transmit_error_flag <= 1'b0;
      end else if (sr_pulse) begin
         transmit_error_flag <= 1'b0;
      end else if (transmit_error_i) begin
         transmit_error_flag <= 1'b1;
      end else if (err_wr && wdata_i[TX_ERR_BIT]) begin
         transmit_error_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         receive_error_flag <= 1'b0;
      end else if (sr_pulse) begin
         receive_error_flag <= 1'b0;
      end else if (receive_error_i) begin
         receive_error_flag <= 1'b1;
      end else if (err_wr && wdata_i[RX_ERR_BIT]) begin
         receive_error_flag <= 1'b0;
      end
   end

   // ==========================================================================
   // interrupt status and mask
   logic [EV_WIDTH-1:0] int_status;
   logic [EV_WIDTH-1:0] int_mask;
   logic [EV_WIDTH-1:0] events;

   assign events[EV_DONE_BIT]    = sr_done;
   assign events[EV_TIMEOUT_BIT] = sr_timeout;
   assign events[EV_TX_ERR_BIT]  = transmit_error_i;
   assign events[EV_RX_ERR_BIT]  = receive_error_i;

   for (genvar i = 0; i < EV_WIDTH; i++) begin : g_ev
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            int_status[i] <= 1'b0;
         end else if (events[i]) begin
            int_status[i] <= 1'b1;
         end else if (sts_wr && wdata_i[i]) begin
            int_status[i] <= 1'b0;
         end
      end
   end

   // mask is kept across soft reset so software keeps its interrupt setup
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         int_mask <= EV_MASK_RST;
      end else if (msk_wr) begin
         int_mask <= wdata_i[EV_WIDTH-1:0];
      end
   end

   assign irq_o = |(int_status & int_mask);

   // ==========================================================================
   // read path
   logic [31:0] cfg_word;
   logic [31:0] err_word;
   logic [31:0] next_rdata;

   // config word: only the low four bits exist, the rest read zero
   always_comb begin
      cfg_word                 = 32'h00000000;
      cfg_word[STRAP_BIT]      = external_phy_present_strap;
      cfg_word[MII_SELECT_BIT] = mii_port_external_select;
      cfg_word[TIMEOUT_BIT]    = soft_reset_timeout_flag;
      cfg_word[SOFT_RESET_BIT] = soft_reset_request;
   end

   always_comb begin
      err_word             = 32'h00000000;
      err_word[TX_ERR_BIT] = transmit_error_flag;
      err_word[RX_ERR_BIT] = receive_error_flag;
   end

   always_comb begin
      next_rdata = 32'h00000000;
      case (addr_i)
         CONFIG_OFS: begin
            next_rdata = cfg_word;
         end
         INT_STATUS_OFS: begin
            next_rdata[EV_WIDTH-1:0] = int_status;
         end
         INT_MASK_OFS: begin
            next_rdata[EV_WIDTH-1:0] = int_mask;
         end
         ERR_STATUS_OFS: begin
            next_rdata = err_word;
         end
         default: begin
            next_rdata = 32'h00000000;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 32'h00000000;
      end else if (rd_i) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= 32'h00000000;
      end
   end
endmodule
`default_nettype wire

// *** rtl/soft_reset_seq.sv ***
`timescale 1ns/10ps
`default_nettype none
module soft_reset_seq
   import config_pkg::*;
#(
   parameter int TIMEOUT_CYC = RESET_TIMEOUT_CYC
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic start_i,
   input  wire logic phy_running_i,
   output logic      busy_o,
   output logic      done_o,
   output logic      timeout_o,
   output logic      reset_pulse_o
);
   if (TIMEOUT_CYC < 2 || TIMEOUT_CYC > 2**24 - 1) begin : g_bad_timeout
      $error("soft_reset_seq: TIMEOUT_CYC out of range");
   end

   soft_reset_request_state_t state;
   logic [23:0] cnt;

   // ==========================================================================
   // sequencer: wait for phy clocks, then hold internal reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state     <= SR_IDLE;
         cnt       <= 24'h000000;
         done_o    <= 1'b0;
         timeout_o <= 1'b0;
      end else begin
         done_o    <= 1'b0;
         timeout_o <= 1'b0;
         case (state)
            SR_IDLE: begin
               cnt <= 24'h000000;
               if (start_i) begin
                  state <= SR_CHECK;
               end
            end
            SR_CHECK: begin
               if (phy_running_i) begin
                  state <= SR_HOLD;
                  cnt   <= 24'h000000;
               end else if (cnt == 24'(TIMEOUT_CYC - 1)) begin
                  state     <= SR_IDLE;
                  timeout_o <= 1'b1;
               end else begin
                  cnt <= cnt + 24'h000001;
               end
            end
            SR_HOLD: begin
               if (cnt == 24'(RESET_HOLD_CYC - 1)) begin
                  state  <= SR_IDLE;
                  done_o <= 1'b1;
               end else begin
                  cnt <= cnt + 24'h000001;
               end
            end
            default: begin
               state <= SR_IDLE;
            end
         endcase
      end
   end

   assign busy_o        = (state != SR_IDLE);
   assign reset_pulse_o = (state == SR_HOLD);
endmodule
`default_nettype wire
